// ==== include/rms_params.svh ====
// constants of the reset, supply monitor and status divider register bank
// assumes a 16-bit register word and a 24-bit serial frame: command byte plus data word
`ifndef RMS_PARAMS_SVH
`define RMS_PARAMS_SVH

// register addresses, low nibble of the command byte
`define RMS_ADDR_SUPPLY 4'h6
`define RMS_ADDR_SOFT_RESET 4'h7
`define RMS_ADDR_DIVIDER 4'h9

// command byte fields
`define RMS_CMD_READ_BIT 7
`define RMS_CMD_SUBSYS_MSB 5
`define RMS_CMD_SUBSYS_LSB 4
`define RMS_CMD_ADDR_MSB 3

// this subsystem's code on the subsystem select field
`define RMS_SUBSYS_ID 2'h0

// supply monitor values
`define RMS_SUPPLY_POR 16'hcafe
`define RMS_SUPPLY_WRITTEN 16'habba
`define RMS_SUPPLY_ALT 16'hbaab

// soft reset key and hardware version (version value is arbitrary)
`define RMS_RESET_KEY 16'ha5a5
`define RMS_HW_VERSION 16'h0001

// status divider field
`define RMS_DIV_RESET 3'h0
`define RMS_DIV_MAX 3'h6

// frame bit counts
`define RMS_CMD_BITS 5'h08
`define RMS_FIRST_SHIFT 5'h09
`define RMS_FRAME_BITS 5'h18

`endif

// ==== include/rms_pkg.sv ====
// types shared by the register bank
// assumes rms_params.svh for all numeric constants
package rms_pkg;

    // serial frame progress
    typedef enum logic [1:0] {
        st_idle,
        st_shift,
        st_ignore
    } rms_state_e;

    // one register word
    typedef logic [15:0] rms_word_t;

endpackage

// ==== design/rms_sync.sv ====
// two flip-flop synchroniser for a group of asynchronous pins
// assumes the inputs are quasi-static levels relative to core_clk
`timescale 1ns/1ps

module rms_sync #(
    parameter int WIDTH = 1
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    // first stage, read only by the second stage
    logic [WIDTH-1:0] meta;

    // both stages clear to zero under reset
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            meta <= '0;
            sync_out <= '0;
        end else begin
            meta <= async_in;
            sync_out <= meta;
        end
    end

endmodule

// ==== design/rms_top.sv ====
// serial-port register bank: soft reset key, supply monitor, status toggle divider
// assumes a host that frames commands with chip select and clocks in mode 0;
// every pin but core_clk and rst is asynchronous to core_clk and is synchronised before use
//
// What this block does
// - key write resets subsystem at frame end
// - soft reset returns all state to default
// - soft reset register reads hardware version
// - supply monitor holds 0xcafe after power-up
// - any supply monitor write sets 0xabba
// - power-on reset restores 0xcafe
// - after a write, each supply monitor read alternates abba/baab
// - analog failure clears channels, not monitor
// - divider field bits 2:0, values 0..6
// - status pin toggles every 2^divider triggers
`timescale 1ns/1ps
`include "rms_params.svh"

module rms_top (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic spi_sclk,
    input wire logic spi_cs_n,
    input wire logic spi_mosi,
    input wire logic trigger_pin,
    input wire logic analog_supply_fail,
    output logic spi_miso,
    output logic spi_miso_oe,
    output logic status_output_pin,
    output logic dac_clear
);

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisation

    logic [4:0] pins_s; // synchronised pins
    logic sclk_s;
    logic cs_n_s;
    logic mosi_s;
    logic trig_s;
    logic afail_s;

    // chip select travels inverted, so a synchroniser cleared by reset reads as
    // deselected and no false frame edge follows the release of reset
    rms_sync #(.WIDTH(5)) u_sync (
        .core_clk(core_clk),
        .rst(rst),
        .async_in({spi_sclk, ~spi_cs_n, spi_mosi, trigger_pin, analog_supply_fail}),
        .sync_out(pins_s)
    );

    assign {sclk_s, cs_n_s, mosi_s, trig_s, afail_s} = pins_s ^ 5'h08;

    ////////////////////////////////////////////////////////////////////////////
    // serial frame and register state

    rms_pkg::rms_state_e state, next_state;
    logic [4:0] bit_cnt, next_bit_cnt; // sclk rising edges seen in frame
    logic [7:0] cmd, next_cmd; // command byte
    rms_pkg::rms_word_t data_in, next_data_in; // write data word
    rms_pkg::rms_word_t shift_out, next_shift_out; // read data, msb first
    rms_pkg::rms_word_t supply_monitor, next_supply_monitor;
    logic [2:0] divider, next_divider; // status toggle divider field
    logic soft_rst, next_soft_rst; // one-cycle software reset
    logic sclk_q, next_sclk_q;
    logic cs_n_q, next_cs_n_q;
    logic next_miso;
    logic next_miso_oe;

    logic sclk_rise; // edge strobes from synchronised pins
    logic sclk_fall;
    logic cs_fall;
    logic cs_rise;
    logic wr_commit; // full write frame ended this cycle
    logic load_read; // read command completed this cycle
    logic [7:0] cmd_now; // command byte including the bit just sampled
    logic [3:0] wr_addr;

    assign sclk_rise = sclk_s & ~sclk_q;
    assign sclk_fall = ~sclk_s & sclk_q;
    assign cs_fall = ~cs_n_s & cs_n_q;
    assign cs_rise = cs_n_s & ~cs_n_q;
    assign cmd_now = {cmd[6:0], mosi_s};
    assign wr_addr = cmd[`RMS_CMD_ADDR_MSB:0];
    // only a frame of exactly command plus one word commits
    assign wr_commit = cs_rise && (state == rms_pkg::st_shift)
        && (bit_cnt == `RMS_FRAME_BITS) && !cmd[`RMS_CMD_READ_BIT];
    assign load_read = (state == rms_pkg::st_shift) && !cs_fall && !cs_rise && sclk_rise
        && (bit_cnt == `RMS_CMD_BITS - 5'h01) && cmd_now[`RMS_CMD_READ_BIT]
        && (cmd_now[`RMS_CMD_SUBSYS_MSB:`RMS_CMD_SUBSYS_LSB] == `RMS_SUBSYS_ID);

    // read value of each address; unmapped addresses read zero
    function automatic rms_pkg::rms_word_t read_value(input logic [3:0] addr,
                                                      input rms_pkg::rms_word_t mon,
                                                      input logic [2:0] div);
        read_value = 16'h0000;
        case (addr)
            `RMS_ADDR_SUPPLY: read_value = mon;
            `RMS_ADDR_SOFT_RESET: read_value = `RMS_HW_VERSION;
            `RMS_ADDR_DIVIDER: read_value = {13'h0000, div};
            default: read_value = 16'h0000;
        endcase
    endfunction

    // next values of frame, registers and read path
    always_comb begin
        next_state = state;
        next_bit_cnt = bit_cnt;
        next_cmd = cmd;
        next_data_in = data_in;
        next_shift_out = shift_out;
        next_supply_monitor = supply_monitor;
        next_divider = divider;
        next_soft_rst = 1'b0;
        next_sclk_q = sclk_s;
        next_cs_n_q = cs_n_s;
        next_miso_oe = spi_miso_oe;
        if (cs_fall) begin
            // new frame; a half-finished one is simply dropped
            next_state = rms_pkg::st_shift;
            next_bit_cnt = 5'h00;
            next_shift_out = 16'h0000;
        end else if (cs_rise) begin
            next_state = rms_pkg::st_idle;
            next_miso_oe = 1'b0;
            if (wr_commit) begin
                case (wr_addr)
                    `RMS_ADDR_SUPPLY: next_supply_monitor = `RMS_SUPPLY_WRITTEN;
                    `RMS_ADDR_SOFT_RESET: next_soft_rst = (data_in == `RMS_RESET_KEY);
                    // an illegal divider write is ignored
                    `RMS_ADDR_DIVIDER: begin
                        if (data_in[2:0] <= `RMS_DIV_MAX) begin
                            next_divider = data_in[2:0];
                        end
                    end
                    default: next_divider = divider;
                endcase
            end
        end else if (state == rms_pkg::st_shift && sclk_rise) begin
            next_bit_cnt = bit_cnt + 5'h01;
            if (bit_cnt < `RMS_CMD_BITS) begin
                next_cmd = cmd_now;
            end else if (bit_cnt < `RMS_FRAME_BITS) begin
                next_data_in = {data_in[14:0], mosi_s};
            end else begin
                // overlong frame: no commit
                next_state = rms_pkg::st_ignore;
                next_miso_oe = 1'b0;
            end
            if (bit_cnt == `RMS_CMD_BITS - 5'h01) begin
                if (cmd_now[`RMS_CMD_SUBSYS_MSB:`RMS_CMD_SUBSYS_LSB] != `RMS_SUBSYS_ID) begin
                    // another subsystem's frame, keep the line released
                    next_state = rms_pkg::st_ignore;
                end else if (load_read) begin
                    next_shift_out = read_value(cmd_now[3:0], supply_monitor, divider);
                    next_miso_oe = 1'b1;
                    if (cmd_now[3:0] == `RMS_ADDR_SUPPLY) begin
                        if (supply_monitor == `RMS_SUPPLY_WRITTEN) begin
                            next_supply_monitor = `RMS_SUPPLY_ALT;
                        end else if (supply_monitor == `RMS_SUPPLY_ALT) begin
                            next_supply_monitor = `RMS_SUPPLY_WRITTEN;
                        end
                    end
                end
            end
        end else if (state == rms_pkg::st_shift && sclk_fall && cmd[`RMS_CMD_READ_BIT]
                     && bit_cnt >= `RMS_FIRST_SHIFT) begin
            // next bit on the falling edge, host samples on the rising one
            next_shift_out = {shift_out[14:0], 1'b0};
        end
        if (soft_rst) begin
            next_state = rms_pkg::st_idle;
            next_bit_cnt = 5'h00;
            next_cmd = 8'h00;
            next_data_in = 16'h0000;
            next_shift_out = 16'h0000;
            next_supply_monitor = `RMS_SUPPLY_POR;
            next_divider = `RMS_DIV_RESET;
            next_miso_oe = 1'b0;
        end
        next_miso = next_shift_out[15];
    end

    // frame and register flops; power-on values
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state <= rms_pkg::st_idle;
            bit_cnt <= 5'h00;
            cmd <= 8'h00;
            data_in <= 16'h0000;
            shift_out <= 16'h0000;
            supply_monitor <= `RMS_SUPPLY_POR;
            divider <= `RMS_DIV_RESET;
            soft_rst <= 1'b0;
            sclk_q <= 1'b0;
            cs_n_q <= 1'b1;
            spi_miso <= 1'b0;
            spi_miso_oe <= 1'b0;
        end else begin
            state <= next_state;
            bit_cnt <= next_bit_cnt;
            cmd <= next_cmd;
            data_in <= next_data_in;
            shift_out <= next_shift_out;
            supply_monitor <= next_supply_monitor;
            divider <= next_divider;
            soft_rst <= next_soft_rst;
            sclk_q <= next_sclk_q;
            cs_n_q <= next_cs_n_q;
            spi_miso <= next_miso;
            spi_miso_oe <= next_miso_oe;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // status pin divider and analog clear

    logic trig_q, next_trig_q;
    logic [5:0] trig_cnt, next_trig_cnt; // triggers since last toggle
    logic next_status;
    logic next_dac_clear;
    logic trig_edge;
    logic [5:0] period_m1; // 2^divider - 1

    assign trig_edge = trig_s & ~trig_q;
    assign period_m1 = 6'((7'h01 << divider) - 7'h01);

    // counts trigger edges; the count is not resized when divider changes
    always_comb begin
        next_trig_q = trig_s;
        next_trig_cnt = trig_cnt;
        next_status = status_output_pin;
        // analog failure drives channel clear only
        next_dac_clear = afail_s;
        if (trig_edge) begin
            if (trig_cnt >= period_m1) begin
                next_trig_cnt = 6'h00;
                next_status = ~status_output_pin;
            end else begin
                next_trig_cnt = trig_cnt + 6'h01;
            end
        end
        if (soft_rst) begin
            next_trig_cnt = 6'h00;
            next_status = 1'b0;
        end
    end

    // status flops
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            trig_q <= 1'b0;
            trig_cnt <= 6'h00;
            status_output_pin <= 1'b0;
            dac_clear <= 1'b0;
        end else begin
            trig_q <= next_trig_q;
            trig_cnt <= next_trig_cnt;
            status_output_pin <= next_status;
            dac_clear <= next_dac_clear;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // assertions

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    a_key_soft_reset: assert property (
        (wr_commit && wr_addr == `RMS_ADDR_SOFT_RESET && data_in == `RMS_RESET_KEY)
        |=> soft_rst ##1 (supply_monitor == `RMS_SUPPLY_POR))
        else $error("key write did not reset the subsystem");
    a_soft_reset_clears: assert property (
        soft_rst |=> (divider == `RMS_DIV_RESET && !status_output_pin
            && state == rms_pkg::st_idle && trig_cnt == 6'h00 && !spi_miso_oe))
        else $error("soft reset left state behind");
    a_version_readback: assert property (
        (load_read && cmd_now[3:0] == `RMS_ADDR_SOFT_RESET && !soft_rst)
        |=> (shift_out == `RMS_HW_VERSION && spi_miso_oe))
        else $error("soft reset register did not read version");
    a_no_false_reset: assert property (
        (wr_commit && data_in != `RMS_RESET_KEY) |=> !soft_rst)
        else $error("soft reset without key");
    a_supply_por_hold: assert property (
        (supply_monitor == `RMS_SUPPLY_POR && !(wr_commit && wr_addr == `RMS_ADDR_SUPPLY))
        |=> supply_monitor == `RMS_SUPPLY_POR)
        else $error("power-up monitor value changed without write");
    a_supply_written: assert property (
        (wr_commit && wr_addr == `RMS_ADDR_SUPPLY && !soft_rst)
        |=> supply_monitor == `RMS_SUPPLY_WRITTEN)
        else $error("monitor write did not give abba");
    a_supply_values: assert property (
        supply_monitor == `RMS_SUPPLY_POR || supply_monitor == `RMS_SUPPLY_WRITTEN
        || supply_monitor == `RMS_SUPPLY_ALT)
        else $error("monitor holds an undefined value");
    a_supply_alternate: assert property (
        (load_read && cmd_now[3:0] == `RMS_ADDR_SUPPLY && !soft_rst
            && supply_monitor != `RMS_SUPPLY_POR)
        |=> (supply_monitor != $past(supply_monitor) && shift_out == $past(supply_monitor)))
        else $error("monitor did not alternate after read");
    a_clear_follows: assert property (
        afail_s |=> (dac_clear && ($stable(supply_monitor) || $past(soft_rst)
            || $past(wr_commit) || $past(load_read))))
        else $error("analog failure did not clear channels");
    a_divider_legal: assert property (
        divider <= `RMS_DIV_MAX)
        else $error("divider field out of range");
    a_status_toggle: assert property (
        (!soft_rst && trig_edge && trig_cnt >= period_m1) |=> $changed(status_output_pin))
        else $error("status pin missed its toggle");
    a_status_quiet: assert property (
        (!soft_rst && !(trig_edge && trig_cnt >= period_m1)) |=> $stable(status_output_pin))
        else $error("status pin toggled early");

    c_supply_read: cover property (load_read && cmd_now[3:0] == `RMS_ADDR_SUPPLY);
    c_soft_reset: cover property (soft_rst);
    c_status_toggle: cover property ($changed(status_output_pin) && divider != 3'h0);
    c_divider_write: cover property (wr_commit && wr_addr == `RMS_ADDR_DIVIDER);

endmodule

// ==== testbench/rms_host_model.sv ====
// host model: frames commands on the serial port in mode 0
// assumes the block samples sclk with its own clock, so the link runs slowly
`timescale 1ns/1ps
`include "rms_params.svh"

module rms_host_model (
    input wire logic core_clk,
    output logic spi_sclk,
    output logic spi_cs_n,
    output logic spi_mosi,
    input wire logic spi_miso,
    input wire logic spi_miso_oe
);
    // link idles with clock low and chip select high
    initial begin
        spi_sclk = 1'b0;
        spi_cs_n = 1'b1;
        spi_mosi = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // one frame of a chosen number of rising edges; 125 ns link period,
    // kept off every core_clk edge; bits past the 24th are noise
    task automatic xfer(input logic rd, input logic [1:0] sub, input logic [3:0] addr,
                        input logic [15:0] wdata, input int edges,
                        output logic [15:0] rdata, output logic oe_seen);
        logic [23:0] frame;
        int i;
        frame = {rd, 1'b0, sub, addr, wdata};
        rdata = 16'h0000;
        oe_seen = 1'b0;
        // start 2 ns past a core_clk edge: with a 62.5 ns half period no pin
        // then moves on a rising or falling core_clk edge
        @(posedge core_clk);
        #2;
        spi_cs_n = 1'b0;
        for (i = 0; i < edges; i++) begin
            spi_mosi = (i < 24) ? frame[23 - i] : ~spi_mosi;
            #62.5;
            spi_sclk = 1'b1;
            // answer bits sit on rising edges 9 to 24
            if (i >= 8 && i < 24) begin
                rdata = {rdata[14:0], spi_miso};
                oe_seen = oe_seen | spi_miso_oe;
            end
            #62.5;
            spi_sclk = 1'b0;
        end
        #62.5;
        spi_cs_n = 1'b1;
        // released data line shows the inverse, never a stale bit
        spi_mosi = ~spi_mosi;
        // gap between frames well beyond four core cycles
        #100;
    endtask

    function automatic logic supply_failed(input logic [15:0] w);
        return w === `RMS_SUPPLY_POR;
    endfunction
endmodule

// ==== testbench/test_rms_top.sv ====
// self-checking bench for the reset key, supply monitor and divider bank
// assumes rms_host_model drives the serial pins; the bench drives the rest
`timescale 1ns/1ps
`include "rms_params.svh"

module test_rms_top;
    logic core_clk = 1'b0; // 100 MHz system clock
    logic rst = 1'b1; // power-on reset, held at start
    logic trigger_pin = 1'b0; // trigger pulses
    logic analog_supply_fail = 1'b0; // analog supply state
    logic spi_sclk; // serial pins from the host model
    logic spi_cs_n;
    logic spi_mosi;
    logic spi_miso;
    logic spi_miso_oe;
    logic status_output_pin;
    logic dac_clear;
    logic [15:0] rdata; // last word read
    logic oe_seen; // miso enable seen during a frame
    int err_count = 0;
    int compares = 0;
    int d;

    always #5 core_clk = ~core_clk;

    rms_top DUT (.core_clk(core_clk), .rst(rst), .spi_sclk(spi_sclk),
        .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .trigger_pin(trigger_pin),
        .analog_supply_fail(analog_supply_fail), .spi_miso(spi_miso),
        .spi_miso_oe(spi_miso_oe), .status_output_pin(status_output_pin),
        .dac_clear(dac_clear));

    rms_host_model host (.core_clk(core_clk), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
        .spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe));

    ////////////////////////////////////////////////////////////////////////////////
    // shared helpers
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic print_verdict();
        if (err_count == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [3:0] addr, input logic [15:0] data);
        host.xfer(1'b0, `RMS_SUBSYS_ID, addr, data, 24, rdata, oe_seen);
    endtask

    task automatic rd(input logic [3:0] addr);
        host.xfer(1'b1, `RMS_SUBSYS_ID, addr, 16'h0000, 24, rdata, oe_seen);
    endtask

    // one trigger pulse, three cycles high and three low, then let outputs settle
    task automatic pulse();
        @(posedge core_clk);
        trigger_pin <= 1'b1;
        repeat (3) @(posedge core_clk);
        trigger_pin <= 1'b0;
        repeat (3) @(posedge core_clk);
        #1;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_power_up();
        rd(`RMS_ADDR_SUPPLY);
        check("supply_por", rdata, 16'hcafe);
        rd(`RMS_ADDR_SUPPLY);
        check("supply_failed", host.supply_failed(rdata), 1'b1);
        rd(`RMS_ADDR_DIVIDER);
        check("divider_por", rdata, 16'h0000);
    endtask

    // written value ignored, then reads alternate
    task automatic t_monitor();
        wr(`RMS_ADDR_SUPPLY, 16'h1234);
        rd(`RMS_ADDR_SUPPLY);
        check("supply_written", rdata, 16'habba);
        rd(`RMS_ADDR_SUPPLY);
        check("supply_alt", rdata, 16'hbaab);
        rd(`RMS_ADDR_SUPPLY);
        check("supply_back", rdata, 16'habba);
    endtask

    // a near-miss key leaves state alone; the real key clears it
    task automatic t_soft_reset();
        wr(`RMS_ADDR_DIVIDER, 16'h0002);
        wr(`RMS_ADDR_SOFT_RESET, 16'ha5a4);
        rd(`RMS_ADDR_DIVIDER);
        check("divider_kept", rdata, 16'h0002);
        rd(`RMS_ADDR_SOFT_RESET);
        check("hw_version", rdata, `RMS_HW_VERSION);
        check("oe_on_read", oe_seen, 1'b1);
        wr(`RMS_ADDR_SOFT_RESET, 16'ha5a5);
        rd(`RMS_ADDR_SUPPLY);
        check("supply_after_key", rdata, 16'hcafe);
        rd(`RMS_ADDR_DIVIDER);
        check("divider_after_key", rdata, 16'h0000);
    endtask

    // every legal divider: pin holds for 2^d - 1 pulses, toggles on the next
    task automatic t_divider();
        for (d = 0; d < 7; d++) begin
            wr(`RMS_ADDR_SOFT_RESET, 16'ha5a5);
            wr(`RMS_ADDR_DIVIDER, {13'h1fff, d[2:0]});
            rd(`RMS_ADDR_DIVIDER);
            check("divider_rb", rdata, {13'h0000, d[2:0]});
            repeat ((1 << d) - 1) pulse();
            check("status_hold", status_output_pin, 1'b0);
            pulse();
            check("status_toggle", status_output_pin, 1'b1);
        end
        wr(`RMS_ADDR_DIVIDER, 16'h0007);
        rd(`RMS_ADDR_DIVIDER);
        check("divider_seven", rdata, 16'h0006);
    endtask

    // other subsystem, short and long frames, unmapped address
    task automatic t_refused();
        host.xfer(1'b1, 2'h1, `RMS_ADDR_DIVIDER, 16'h0000, 24, rdata, oe_seen);
        check("oe_other_subsys", oe_seen, 1'b0);
        host.xfer(1'b0, 2'h3, `RMS_ADDR_DIVIDER, 16'h0002, 24, rdata, oe_seen);
        host.xfer(1'b0, `RMS_SUBSYS_ID, `RMS_ADDR_DIVIDER, 16'h0003, 23, rdata, oe_seen);
        host.xfer(1'b0, `RMS_SUBSYS_ID, `RMS_ADDR_DIVIDER, 16'h0004, 25, rdata, oe_seen);
        rd(`RMS_ADDR_DIVIDER);
        check("divider_refused", rdata, 16'h0006);
        rd(4'h3);
        check("unmapped", rdata, 16'h0000);
    endtask

    // analog failure clears channels but leaves the monitor alone
    task automatic t_analog();
        wr(`RMS_ADDR_SUPPLY, 16'h0000);
        @(posedge core_clk);
        analog_supply_fail <= 1'b1;
        repeat (5) @(posedge core_clk);
        #1;
        check("clear_on", dac_clear, 1'b1);
        rd(`RMS_ADDR_SUPPLY);
        check("supply_analog", rdata, 16'habba);
        @(posedge core_clk);
        analog_supply_fail <= 1'b0;
        repeat (5) @(posedge core_clk);
        #1;
        check("clear_off", dac_clear, 1'b0);
    endtask

    // digital supply collapse in mid-run brings back the power-up value
    task automatic t_power_fail();
        @(posedge core_clk);
        rst <= 1'b1;
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        repeat (3) @(posedge core_clk);
        rd(`RMS_ADDR_SUPPLY);
        check("supply_collapse", rdata, 16'hcafe);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence after a ten-cycle reset
    initial begin
        repeat (10) @(posedge core_clk);
        rst <= 1'b0;
        repeat (3) @(posedge core_clk);
        t_power_up();
        t_monitor();
        t_soft_reset();
        t_divider();
        t_refused();
        t_analog();
        t_power_fail();
        print_verdict();
    end

    // watchdog: the run needs about 155 us, so 600 us means a hang
    initial begin
        #600000;
        err_count++;
        print_verdict();
    end
endmodule
